// [common/mpg_pkg.sv]
// package of constants and types for the marker pulse gate generator
package mpg_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned MARKER_COUNT = 3;
  localparam int unsigned TIME_WIDTH = 24;
  localparam int unsigned APB_ADDR_WIDTH = 8;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FRAME_LEN = 8'h08;
  localparam logic [7:0] OFS_MK_BASE = 8'h10;
  localparam logic [7:0] OFS_MK_STRIDE = 8'h10;
  localparam logic [7:0] OFS_MK_OFFSET = 8'h00;
  localparam logic [7:0] OFS_MK_WIDTH = 8'h04;
  localparam logic [7:0] OFS_MK_CYCLE = 8'h08;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_GATE_LSB = 0;
  localparam int unsigned CTRL_RES_LSB = 2;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_POL_LSB = 10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [TIME_WIDTH-1:0] RST_OFFSET = 24'h000000;
  localparam logic [TIME_WIDTH-1:0] RST_WIDTH = 24'h000001;
  localparam logic [TIME_WIDTH-1:0] RST_CYCLE = 24'h000002;
  localparam logic [TIME_WIDTH-1:0] RST_FRAME_LEN = 24'h000001;
  localparam logic [TIME_WIDTH-1:0] TIME_MIN = 24'h000001;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MPG_GATE_INT = 2'b00,
    MPG_GATE_EXT = 2'b01,
    MPG_GATE_OFF = 2'b10
  } mpg_gate_e;

  typedef enum logic [1:0] {
    MPG_MODE_PATTERN = 2'b00,
    MPG_MODE_EDIT = 2'b01,
    MPG_MODE_SYNC = 2'b10
  } mpg_mode_e;

  typedef enum logic [1:0] {
    MPG_RES_STD = 2'b00,
    MPG_RES_15 = 2'b01,
    MPG_RES_16 = 2'b10
  } mpg_res_e;

  typedef enum logic [1:0] {
    MPG_PH_OFFSET = 2'b00,
    MPG_PH_HIGH = 2'b01,
    MPG_PH_LOW = 2'b10,
    MPG_PH_DONE = 2'b11
  } mpg_phase_e;

endpackage : mpg_pkg

// [src/mpg_marker_synth.sv]
// one synthesised marker channel: offset, width and cycle counter
module mpg_marker_synth #(
  parameter int unsigned TW = 24
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // settings
  input wire logic sync_mode_in,
  input wire logic [TW-1:0] offset_in,
  input wire logic [TW-1:0] width_in,
  input wire logic [TW-1:0] cycle_in,
  // timing
  input wire logic restart_in,
  input wire logic frame_start_in,
  input wire logic sample_en_in,
  // result
  output logic pulse_out
);

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  mpg_pkg::mpg_phase_e phase_reg;
  mpg_pkg::mpg_phase_e phase_next;
  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;
  logic pulse_next;

  wire logic [TW-1:0] cnt_inc = cnt_reg + 1'b1;
  wire logic [TW-1:0] low_len = cycle_in - width_in;
  wire logic restart = restart_in | (sync_mode_in & frame_start_in);
  wire logic zero_low = (low_len == '0);

  // next phase; the caller already clamps width to cycle, or to frame length in sync mode
  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    if (restart) begin
      cnt_next = '0;
      phase_next = (offset_in == '0) ? mpg_pkg::MPG_PH_HIGH : mpg_pkg::MPG_PH_OFFSET;
    end else if (sample_en_in) begin
      case (phase_reg)
        mpg_pkg::MPG_PH_OFFSET: begin
          cnt_next = cnt_inc;
          if (cnt_inc >= offset_in) begin
            cnt_next = '0;
            phase_next = mpg_pkg::MPG_PH_HIGH;
          end
        end
        mpg_pkg::MPG_PH_HIGH: begin
          cnt_next = cnt_inc;
          if (cnt_inc >= width_in) begin
            cnt_next = '0;
            // sync mode ends after one pulse, cycle ignored
            if (sync_mode_in) begin
              phase_next = mpg_pkg::MPG_PH_DONE;
            end else if (zero_low) begin
              phase_next = mpg_pkg::MPG_PH_HIGH;
            end else begin
              phase_next = mpg_pkg::MPG_PH_LOW;
            end
          end
        end
        mpg_pkg::MPG_PH_LOW: begin
          cnt_next = cnt_inc;
          if (cnt_inc >= low_len) begin
            cnt_next = '0;
            phase_next = mpg_pkg::MPG_PH_HIGH;
          end
        end
        default: begin
          cnt_next = '0;
          phase_next = mpg_pkg::MPG_PH_DONE;
        end
      endcase
    end
    pulse_next = (phase_next == mpg_pkg::MPG_PH_HIGH);
  end

  // result left unregistered: the caller's output flop is the only stage,
  // so synthesised and pattern markers share one cycle of latency
  assign pulse_out = pulse_next;

  // state registers
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      phase_reg <= mpg_pkg::MPG_PH_DONE;
      cnt_reg <= '0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : mpg_marker_synth

// [src/mpg_marker_gate.sv]
// marker pulse and sample_gate_bit generator with apb register slave
//
// The implementer's own choices: the APB slave port and the register addresses.
module mpg_marker_gate #(
  parameter int unsigned MARKERS = mpg_pkg::MARKER_COUNT,
  parameter int unsigned TW = mpg_pkg::TIME_WIDTH
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpg_pkg::APB_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // waveform player side
  input wire logic sample_valid_in,
  input wire logic pattern_start_in,
  input wire logic frame_start_in,
  input wire logic [MARKERS-1:0] pattern_marker_in,
  input wire logic sample_gate_bit,
  // external modulation
  input wire logic ext_gate_in,
  // outputs
  output logic [MARKERS-1:0] marker_out,
  output logic sample_gate_bit_out
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [1:0] gate_src_reg;
  logic [1:0] res_reg;
  logic [2*MARKERS-1:0] mode_reg;
  logic [MARKERS-1:0] pol_reg;
  logic [TW-1:0] frame_len_reg;
  logic [TW-1:0] offset_reg [MARKERS];
  logic [TW-1:0] width_reg [MARKERS];
  logic [TW-1:0] cycle_reg [MARKERS];
  logic [31:0] prdata_next;
  logic pslverr_next;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: pready follows the first access cycle
  wire logic acc = psel & penable & ~pready;
  // write lands at the completing edge, when the master samples pready
  wire logic wr_en = psel & penable & pready & pwrite & (&pstrb);
  wire logic hit_ctrl = (paddr == mpg_pkg::OFS_CTRL);
  wire logic hit_stat = (paddr == mpg_pkg::OFS_STATUS);
  wire logic hit_flen = (paddr == mpg_pkg::OFS_FRAME_LEN);
  wire logic [7:0] mk_rel = paddr - mpg_pkg::OFS_MK_BASE;
  wire logic [3:0] mk_idx = mk_rel[7:4];
  wire logic [7:0] mk_fld = {4'h0, mk_rel[3:0]};
  wire logic in_mk = (paddr >= mpg_pkg::OFS_MK_BASE) && (mk_idx < MARKERS) && (mk_fld != 8'h0C);
  wire logic hit_any = hit_ctrl | hit_stat | hit_flen | in_mk;
  wire logic [TW-1:0] wdata_t = pwdata[TW-1:0];

  // write data legalised to allowed ranges
  wire logic [TW-1:0] wdata_min1 = (wdata_t == '0) ? mpg_pkg::TIME_MIN : wdata_t;

  // control word as read back
  wire logic [31:0] ctrl_word = {
    {(32 - mpg_pkg::CTRL_POL_LSB - MARKERS){1'b0}}, pol_reg, mode_reg, res_reg, gate_src_reg};

  // ----------------------------------------------------------------
  // effective marker modes
  // ----------------------------------------------------------------
  logic [2*MARKERS-1:0] eff_mode;
  logic [MARKERS-1:0] synth_pulse;
  logic [MARKERS-1:0] marker_next;
  logic [TW-1:0] eff_width [MARKERS];

  genvar gi;
  generate
    for (gi = 0; gi < MARKERS; gi++) begin : g_mk
      wire logic [1:0] m_req = mode_reg[2*gi +: 2];
      // pattern mode refused at MPG_RES_16, and at MPG_RES_15 on every marker but marker 0
      wire logic no_pat = (res_reg == mpg_pkg::MPG_RES_16)
        | ((res_reg == mpg_pkg::MPG_RES_15) && (gi != 0));
      wire logic [1:0] m_eff = (no_pat && (m_req == mpg_pkg::MPG_MODE_PATTERN)) ? mpg_pkg::MPG_MODE_EDIT : m_req;
      wire logic is_sync = (m_eff == mpg_pkg::MPG_MODE_SYNC);
      // width clamp: to cycle in edit mode, to frame length in sync mode
      wire logic [TW-1:0] lim = is_sync ? frame_len_reg : cycle_reg[gi];
      assign eff_width[gi] = (width_reg[gi] > lim) ? lim : width_reg[gi];
      assign eff_mode[2*gi +: 2] = m_eff;

      mpg_marker_synth #(
        .TW(TW)
      ) u_synth (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .sync_mode_in(is_sync),
        .offset_in(offset_reg[gi]),
        .width_in(eff_width[gi]),
        .cycle_in(cycle_reg[gi]),
        .restart_in(sample_valid_in & pattern_start_in),
        .frame_start_in(sample_valid_in & frame_start_in),
        .sample_en_in(sample_valid_in),
        .pulse_out(synth_pulse[gi])
      );

      // source select then polarity
      wire logic raw = (m_eff == mpg_pkg::MPG_MODE_PATTERN) ? pattern_marker_in[gi]
        : synth_pulse[gi];
      assign marker_next[gi] = raw ^ pol_reg[gi];

      // per-marker timing registers
      always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
          offset_reg[gi] <= mpg_pkg::RST_OFFSET;
          width_reg[gi] <= mpg_pkg::RST_WIDTH;
          cycle_reg[gi] <= mpg_pkg::RST_CYCLE;
        end else if (wr_en && in_mk && (mk_idx == gi)) begin
          if (mk_fld == mpg_pkg::OFS_MK_OFFSET) begin
            offset_reg[gi] <= wdata_t;
          end else if (mk_fld == mpg_pkg::OFS_MK_WIDTH) begin
            width_reg[gi] <= wdata_min1;
          end else if (mk_fld == mpg_pkg::OFS_MK_CYCLE) begin
            cycle_reg[gi] <= wdata_min1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sample_gate_bit source
  // ----------------------------------------------------------------
  // gate is registered so glitches on the external pin are not passed raw
  wire logic gate_next = (gate_src_reg == mpg_pkg::MPG_GATE_INT) ? sample_gate_bit
    : (gate_src_reg == mpg_pkg::MPG_GATE_EXT) ? ext_gate_in
    : 1'b1;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // illegal gate code 2'b11 is stored as off
  wire logic [1:0] gate_wr = (pwdata[mpg_pkg::CTRL_GATE_LSB +: 2] == 2'b11) ? mpg_pkg::MPG_GATE_OFF
    : pwdata[mpg_pkg::CTRL_GATE_LSB +: 2];

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      gate_src_reg <= mpg_pkg::MPG_GATE_INT;
      res_reg <= mpg_pkg::MPG_RES_STD;
      mode_reg <= '0;
      pol_reg <= '0;
    end else if (wr_en && hit_ctrl) begin
      gate_src_reg <= gate_wr;
      res_reg <= pwdata[mpg_pkg::CTRL_RES_LSB +: 2];
      mode_reg <= pwdata[mpg_pkg::CTRL_MODE_LSB +: 2*MARKERS];
      pol_reg <= pwdata[mpg_pkg::CTRL_POL_LSB +: MARKERS];
    end
  end

  // frame length in data points bounds the sync width
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      frame_len_reg <= mpg_pkg::RST_FRAME_LEN;
    end else if (wr_en && hit_flen) begin
      frame_len_reg <= wdata_min1;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    prdata_next = 32'h00000000;
    pslverr_next = ~hit_any;
    if (hit_ctrl) begin
      prdata_next = ctrl_word;
    end else if (hit_stat) begin
      prdata_next = {{(32 - 2*MARKERS - MARKERS - 1){1'b0}}, sample_gate_bit_out, marker_out, eff_mode};
    end else if (hit_flen) begin
      prdata_next = {{(32 - TW){1'b0}}, frame_len_reg};
    end else if (in_mk) begin
      if (mk_fld == mpg_pkg::OFS_MK_OFFSET) begin
        prdata_next = {{(32 - TW){1'b0}}, offset_reg[mk_idx[1:0]]};
      end else if (mk_fld == mpg_pkg::OFS_MK_WIDTH) begin
        prdata_next = {{(32 - TW){1'b0}}, width_reg[mk_idx[1:0]]};
      end else begin
        prdata_next = {{(32 - TW){1'b0}}, cycle_reg[mk_idx[1:0]]};
      end
    end
  end

  // ----------------------------------------------------------------
  // apb answer and output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      marker_out <= '0;
      sample_gate_bit_out <= 1'b1;
    end else begin
      pready <= acc;
      pslverr <= acc & pslverr_next;
      prdata <= (acc & ~pwrite) ? prdata_next : 32'h00000000;
      marker_out <= marker_next;
      sample_gate_bit_out <= gate_next;
    end
  end

endmodule : mpg_marker_gate

// [tb/mpg_marker_gate_checker.sv]
// assertion checker bound to the marker pulse gate generator
module mpg_marker_gate_checker #(
  parameter int unsigned MARKERS = 3
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpg_pkg::APB_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sources and outputs
  input wire logic [MARKERS-1:0] pattern_marker_in,
  input wire logic sample_gate_bit,
  input wire logic ext_gate_in,
  input wire logic [MARKERS-1:0] marker_out,
  input wire logic sample_gate_bit_out
);
  // ------
  // control shadow
  // ------
  logic [31:0] ctl_reg;
  // taken at the slave's own write edge, so no skew against its setting
  wire ctl_wr = psel && penable && pready && pwrite && pstrb == 4'hF && paddr == mpg_pkg::OFS_CTRL;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) ctl_reg <= 32'h0;
    else if (ctl_wr) ctl_reg <= pwdata;
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stale prdata");
  marker_rst_a: assert property ($fell(srst_in) |-> marker_out == '0) else $error("marker set");
  gate_rst_a: assert property ($fell(srst_in) |=> sample_gate_bit_out == $past(sample_gate_bit))
    else $error("reset gate");
  gate_int_a: assert property (ctl_reg[1:0] == 2'b00 |=> sample_gate_bit_out == $past(sample_gate_bit))
    else $error("int gate");
  gate_ext_a: assert property (ctl_reg[1:0] == 2'b01 |=> sample_gate_bit_out == $past(ext_gate_in))
    else $error("ext gate");
  gate_off_a: assert property (ctl_reg[1] |=> sample_gate_bit_out) else $error("gate shut");
  mark_pat_a: assert property (ctl_reg[5:3] == 3'b000 |=> marker_out[0] == $past(pattern_marker_in[0] ^ ctl_reg[10]))
    else $error("pattern marker");
  cover property (ctl_reg[1:0] == 2'b01 ##1 $rose(sample_gate_bit_out));
  cover property (pslverr);
  cover property (ctl_reg[5:4] == 2'b01 ##1 $rose(marker_out[0]));
endmodule : mpg_marker_gate_checker

bind mpg_marker_gate mpg_marker_gate_checker #(.MARKERS(MARKERS)) i_mpg_marker_gate_checker (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pattern_marker_in(pattern_marker_in), .sample_gate_bit(sample_gate_bit), .ext_gate_in(ext_gate_in),
  .marker_out(marker_out), .sample_gate_bit_out(sample_gate_bit_out)
);

// [tb/mpg_ext_source.sv]
// far side model: external modulation source for the gate input
module mpg_ext_source (
  // level chosen by the bench
  input wire logic level_in,
  // modulation line, high lets rf pass
  output logic ext_gate_out
);
  // active-high drive, no inversion on the way
  assign ext_gate_out = level_in;
endmodule : mpg_ext_source

// [tb/tb_top.sv]
// self-checking testbench for the marker pulse gate generator
`define CHK(g, e, s) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: %s", $time, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // signals and notes
  // ------
  typedef struct {int t; logic [3:0] v;} mpg_out_s;
  typedef struct {logic rd; logic er; logic [31:0] d; logic [31:0] m;} mpg_apb_s;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sample_valid = 1'b0, pattern_start = 1'b0;
  logic frame_start = 1'b0, gate_bit = 1'b0, ext_level = 1'b0, ext_gate, pready, pslverr, sample_gate_bit_out;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] pat_mk = 3'h0, marker_out, pol;
  logic [1:0] gsel, mode [3];
  int n_errors = 0, tests_run = 0, cyc = 0, fl, off [3], wd [3], cy [3];
  mpg_out_s outq [$];
  mpg_apb_s apq [$];
  mpg_marker_gate i_mpg_marker_gate (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid_in(sample_valid), .pattern_start_in(pattern_start), .frame_start_in(frame_start),
    .pattern_marker_in(pat_mk), .sample_gate_bit(gate_bit), .ext_gate_in(ext_gate),
    .marker_out(marker_out), .sample_gate_bit_out(sample_gate_bit_out)
  );
  mpg_ext_source i_mpg_ext_source (.level_in(ext_level), .ext_gate_out(ext_gate));
  // 40 MHz clock and cycle count
  always #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;
  function automatic int mn(int a, int b);
    return (a < b) ? a : b;
  endfunction : mn
  function automatic logic [7:0] ma(int i, logic [7:0] f);
    return 8'(mpg_pkg::OFS_MK_BASE + mpg_pkg::OFS_MK_STRIDE * i + f);
  endfunction : ma
  // one apb transfer, request held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic er = 1'b0, input logic [3:0] sb = 4'hF);
    @(posedge clk_sys_in);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, sb};
    apq.push_back('{!w, er, d, m});
    @(posedge clk_sys_in);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends this wait
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb
  // apb monitor takes the oldest note per completed transfer
  always @(posedge clk_sys_in) begin : apb_mon
    mpg_apb_s a;
    if (psel && penable && pready === 1'b1) begin
      a = apq.pop_front();
      `CHK(pslverr, a.er, "slave error")
      if (a.rd) `CHK(prdata & a.m, a.d, "read data")
    end
  end
  // output monitor looks once the edge has settled
  always @(posedge clk_sys_in) begin : out_mon
    mpg_out_s o;
    #1;
    if (outq.size() > 0 && outq[0].t <= cyc) begin
      o = outq.pop_front();
      `CHK({sample_gate_bit_out, marker_out}, o.v, "gate or marker")
    end
  end
  // program all three markers, control word, then check effective modes
  task automatic setup(input logic [1:0] g, input logic [1:0] r, input logic [5:0] req);
    gsel = g;
    pol = 3'($urandom);
    fl = $urandom_range(9, 4);
    apb(1, mpg_pkg::OFS_FRAME_LEN, fl, 0);
    for (int i = 0; i < 3; i++) begin
      mode[i] = (req[2*i+:2] == 0 && (r == 2 || (r == 1 && i > 0))) ? 2'd1 : req[2*i+:2];
      off[i] = $urandom_range(5);
      wd[i] = $urandom_range(7, 1);
      cy[i] = $urandom_range(6, 1);
      apb(1, ma(i, mpg_pkg::OFS_MK_OFFSET), off[i], 0);
      apb(1, ma(i, mpg_pkg::OFS_MK_WIDTH), wd[i], 0);
      apb(1, ma(i, mpg_pkg::OFS_MK_CYCLE), cy[i], 0);
    end
    apb(1, mpg_pkg::OFS_CTRL, {19'h0, pol, req, r, g}, 0);
    apb(0, mpg_pkg::OFS_STATUS, {26'h0, mode[2], mode[1], mode[0]}, 32'h3F);
  endtask : setup
  // play one pattern from its first sample, noting each expected output
  task automatic stream(input int len);
    logic [2:0] pm;
    logic [3:0] ev;
    logic gb, el;
    int m;
    for (int n = 0; n < len; n++) begin
      @(posedge clk_sys_in);
      {pm, gb, el} = 5'($urandom);
      {sample_valid, pattern_start, frame_start, pat_mk, gate_bit, ext_level} <= {1'b1, n == 0, n % fl == 0, pm, gb, el};
      m = n % fl;
      for (int i = 0; i < 3; i++) begin
        case (mode[i])
          2'd0: ev[i] = pm[i];
          2'd1: ev[i] = n >= off[i] && (n - off[i]) % cy[i] < mn(wd[i], cy[i]);
          default: ev[i] = m >= off[i] && m - off[i] < mn(wd[i], fl);
        endcase
        ev[i] = ev[i] ^ pol[i];
      end
      ev[3] = gsel[1] ? 1'b1 : gsel[0] ? el : gb;
      // inputs land at the next edge, where the output flop also takes the result; cyc still reads the old count here
      outq.push_back('{cyc + 2, ev});
    end
    @(posedge clk_sys_in);
    {sample_valid, pattern_start, frame_start} <= 3'b000;
  endtask : stream
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    void'($urandom(32'hE56C));
    repeat (10) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    apb(0, mpg_pkg::OFS_CTRL, 0, '1);
    apb(0, ma(2, mpg_pkg::OFS_MK_CYCLE), 2, '1);
    apb(1, ma(1, mpg_pkg::OFS_MK_OFFSET), 5, 0, 0, 4'h3);
    apb(0, ma(1, mpg_pkg::OFS_MK_OFFSET), 0, '1);
    apb(1, ma(0, mpg_pkg::OFS_MK_WIDTH), 0, 0);
    apb(0, ma(0, mpg_pkg::OFS_MK_WIDTH), 1, '1);
    apb(1, ma(0, mpg_pkg::OFS_MK_CYCLE), '1, 0);
    apb(0, ma(0, mpg_pkg::OFS_MK_CYCLE), 32'hFFFFFF, '1);
    apb(0, 8'h1C, 0, '1, 1);
    $display("test registers done");
    for (int g = 0; g < 3; g++) begin
      setup(g, 0, (g == 0) ? 6'h24 : (g == 1) ? 6'h09 : 6'h12);
      stream(30);
      stream(30);
    end
    $display("test modes and gates done");
    for (int r = 1; r < 3; r++) begin
      setup(3, r, 6'h00);
      stream(30);
    end
    $display("test resolution done");
    // let the last noted output be compared before closing
    repeat (2) @(posedge clk_sys_in);
    final_report();
  end
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #200000;
    n_errors++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  end
endmodule : tb_top
